// ---- design/gtimer_pkg.sv ----
// Package for the general timer: register offsets, field layout, resets.
// Assumes a 32-bit plain register port with byte offsets.
package gtimer_pkg;

  // ******************************************************
  // Register offsets (byte addresses)
  // ******************************************************
  localparam logic [7:0] OFF_WIDTH_CFG  = 8'h00;
  localparam logic [7:0] OFF_MODE       = 8'h04;
  localparam logic [7:0] OFF_CONTROL    = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h18;
  localparam logic [7:0] OFF_RAW_STATUS = 8'h1c;
  localparam logic [7:0] OFF_MSK_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h24;
  localparam logic [7:0] OFF_LOAD       = 8'h28;
  localparam logic [7:0] OFF_MATCH      = 8'h30;
  localparam logic [7:0] OFF_PRESCALE   = 8'h38;
  localparam logic [7:0] OFF_VALUE      = 8'h48;

  // ******************************************************
  // Field positions
  // ******************************************************
  localparam int MODE_LSB   = 0;  // timer_mode_field [1:0]
  localparam int CMR_BIT    = 2;  // capture_mode_sel
  localparam int AMS_BIT    = 3;  // alternate_mode_sel
  localparam int EN_BIT     = 0;  // timer_a_enable_bit
  localparam int STALL_BIT  = 1;  // stall_freeze
  localparam int EVT_LSB    = 2;  // event select [3:2]
  localparam int RTCOV_BIT  = 4;  // rtc_stall_override
  localparam int INV_BIT    = 6;  // pwm_invert
  localparam int TO_BIT     = 0;  // time-out flag
  localparam int CM_BIT     = 1;  // count match flag
  localparam int CE_BIT     = 2;  // edge event flag
  localparam int RTC_BIT    = 3;  // rtc match flag

  // ******************************************************
  // Encodings and reset values
  // ******************************************************
  localparam logic [2:0]  CFG_32BIT = 3'h0;
  localparam logic [2:0]  CFG_RTC   = 3'h1;
  localparam logic [2:0]  CFG_16BIT = 3'h4;
  localparam logic [1:0]  MODE_ONESHOT  = 2'h1;
  localparam logic [1:0]  MODE_PERIODIC = 2'h2;
  localparam logic [1:0]  MODE_CAPTURE  = 2'h3;
  localparam logic [1:0]  EVT_RISE = 2'h0;
  localparam logic [1:0]  EVT_FALL = 2'h1;
  localparam logic [1:0]  EVT_BOTH = 2'h3;
  localparam logic [31:0] LOAD16_RST = 32'h0000ffff;
  localparam logic [31:0] LOAD32_RST = 32'hffffffff;
  localparam logic [31:0] RTC_START  = 32'h00000001;
  localparam logic [31:0] ZERO32     = 32'h00000000;
  localparam logic [15:0] ZERO16     = 16'h0000;
  localparam int          RTC_DIV    = 32768;  // 32.768 kHz to 1 Hz

  typedef enum logic [1:0] {
    op_idle, op_count16, op_count32, op_rtc
  } op_t;

endpackage : gtimer_pkg

// ---- design/pin_sync.sv ----
// Three-stage synchroniser with agreement filter for the capture pin.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/10ps
module pin_sync (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic s1;
  logic s2;
  logic s3;

  // Three flops; level changes once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      rise  <= 1'b0;
      fall  <= 1'b0;
      if (s2 == s3 && s3 != level) begin
        level <= s3;
        rise  <= s3;
        fall  <= ~s3;
      end
    end
  end

endmodule : pin_sync

// ---- design/gtimer.sv ----
// General timer: 16-bit one-shot/periodic, edge count, edge time, PWM,
// 32-bit one-shot/periodic and 32-bit RTC. Register port is plain.
// Assumes capture_compare_pin is asynchronous and the RTC clock on it.
//
// Functional notes
// - No prescale in edge and PWM modes
// - Capture-mode zero counts selected edges down
// - Each edge decrements; match sets flags
// - After match reload, clear enable, ignore edges
// - Capture-mode one free-runs from load
// - Edge copies count, sets edge flag
// - Edge-time counter runs, reloads at zero
// - Captured value held until next edge
// - PWM counts down, reloads, no flags
// - PWM active at load, inactive at match
// - Invert bit flips PWM polarity
// - One-shot stops, periodic keeps counting
// - Write one clears flag; mask gates
// - RTC match reloads zero and continues
// - Zero reloads load and prescale, time-out
// - RTC divides to 1 Hz, counts up
// - Stall bit freezes counting
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/10ps
module gtimer
  import gtimer_pkg::*;
#(
  parameter int RTC_DIVIDE = RTC_DIV
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  input  wire logic        capture_compare_pin,
  output logic             pwm_out,
  output logic             ccp_oe,
  output logic             irq_pending
);
  // ******************************************************
  // Registers
  // ******************************************************
  logic [2:0]  width_config_reg;
  logic [3:0]  timer_mode_reg;
  logic [6:0]  control_reg;
  logic [3:0]  irq_mask_reg;
  logic [3:0]  raw_irq_status_reg;
  logic [31:0] interval_load_reg;
  logic [31:0] match_reg;
  logic [7:0]  prescale_reg;
  logic [31:0] timer_value_reg;
  logic [31:0] count;
  logic [7:0]  pre_cnt;
  logic [31:0] rtc_div;
  logic        pin_level;
  logic        pin_rise;
  logic        pin_fall;

  logic [1:0] mode_f;
  logic [1:0] evt;
  logic       en;
  logic       is16;
  logic       is_rtc;
  logic       cap_mode;
  logic       is_pwm;
  logic       is_ecount;
  logic       is_etime;
  logic       stalled;
  logic       edge_hit;
  logic       rtc_tick;
  logic       at_zero;
  logic [31:0] next_count;
  logic       set_to;
  logic       set_cm;
  logic       set_ce;
  logic       set_rtc;
  logic       hw_disable;

  assign mode_f   = timer_mode_reg[MODE_LSB +: 2];
  assign cap_mode = timer_mode_reg[CMR_BIT];
  assign evt      = control_reg[EVT_LSB +: 2];
  assign en       = control_reg[EN_BIT];
  assign is16     = (width_config_reg == CFG_16BIT);
  assign is_rtc   = (width_config_reg == CFG_RTC);
  assign is_pwm   = is16 && timer_mode_reg[AMS_BIT] && !cap_mode
                    && mode_f == MODE_PERIODIC;
  assign is_ecount = is16 && mode_f == MODE_CAPTURE && !cap_mode;
  assign is_etime  = is16 && mode_f == MODE_CAPTURE && cap_mode;
  // RTC ignores stall when the override bit is set
  assign stalled  = control_reg[STALL_BIT] &&
                    !(is_rtc && control_reg[RTCOV_BIT]);
  assign at_zero  = is16 ? (count[15:0] == ZERO16) : (count == ZERO32);

  // Edge qualification by event select; edge time never uses both
  always_comb begin
    case (evt)
      EVT_RISE: edge_hit = pin_rise;
      EVT_FALL: edge_hit = pin_fall;
      EVT_BOTH: edge_hit = is_etime ? pin_rise : (pin_rise | pin_fall);
      default:  edge_hit = pin_rise;
    endcase
  end

  pin_sync u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (capture_compare_pin),
    .level   (pin_level),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // ******************************************************
  // RTC 1 Hz divider on the synchronised 32.768 kHz input
  // ******************************************************
  always_ff @(posedge ref_clk) begin
    if (rst || !en || !is_rtc) begin
      rtc_div  <= ZERO32;
      rtc_tick <= 1'b0;
    end else begin
      rtc_tick <= 1'b0;
      if (pin_rise) begin
        if (rtc_div == 32'(RTC_DIVIDE - 1)) begin
          rtc_div  <= ZERO32;
          rtc_tick <= 1'b1;
        end else begin
          rtc_div <= rtc_div + 32'h00000001;
        end
      end
    end
  end

  // Counter next value and events per mode
  always_comb begin
    next_count = count;
    set_to = 1'b0;
    set_cm = 1'b0;
    set_ce = 1'b0;
    set_rtc = 1'b0;
    hw_disable = 1'b0;
    if (en && !stalled) begin
      if (is_rtc) begin
        if (rtc_tick) begin
          if (count == match_reg) begin
            next_count = ZERO32;
            set_rtc = 1'b1;
          end else begin
            next_count = count + 32'h00000001;
          end
        end
      end else if (is_ecount) begin
        if (edge_hit) begin
          if (count - 32'h00000001 == match_reg) begin
            next_count = interval_load_reg;
            set_cm = 1'b1;
            hw_disable = 1'b1;
          end else begin
            next_count = count - 32'h00000001;
          end
        end
      end else if (is_etime || is_pwm) begin
        set_ce = is_etime && edge_hit;
        next_count = at_zero ? interval_load_reg
                             : count - 32'h00000001;
      end else if (mode_f == MODE_ONESHOT || mode_f == MODE_PERIODIC) begin
        if (is16 && pre_cnt != 8'h00) begin
          next_count = count;
        end else if (at_zero) begin
          next_count = interval_load_reg;
          set_to = 1'b1;
          hw_disable = (mode_f == MODE_ONESHOT);
        end else begin
          next_count = count - 32'h00000001;
        end
      end
    end
  end

  // ******************************************************
  // Counter, prescaler and capture
  // ******************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count <= LOAD16_RST;
    end else if (wr && addr == OFF_LOAD && !is_rtc) begin
      count <= wdata;
    end else if (wr && addr == OFF_WIDTH_CFG && wdata[2:0] == CFG_RTC) begin
      count <= RTC_START;
    end else begin
      count <= next_count;
    end
  end

  // Prescaler only in 16-bit one-shot/periodic
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_cnt <= 8'h00;
    end else if (!en || stalled || !is16 || is_pwm || is_ecount
                 || is_etime) begin
      pre_cnt <= prescale_reg;
    end else if (pre_cnt != 8'h00) begin
      pre_cnt <= pre_cnt - 8'h01;
    end else begin
      pre_cnt <= prescale_reg;
    end
  end

  // Value register: live count, or held capture in edge time
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timer_value_reg <= LOAD16_RST;
    end else if (is_etime) begin
      if (set_ce) begin
        timer_value_reg <= count;
      end
    end else begin
      timer_value_reg <= next_count;
    end
  end

  // ******************************************************
  // Software registers
  // ******************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      width_config_reg  <= 3'h0;
      timer_mode_reg    <= 4'h0;
      irq_mask_reg      <= 4'h0;
      interval_load_reg <= LOAD16_RST;
      match_reg         <= LOAD16_RST;
      prescale_reg      <= 8'h00;
    end else if (wr) begin
      case (addr)
        OFF_WIDTH_CFG: width_config_reg  <= wdata[2:0];
        OFF_MODE:      timer_mode_reg    <= wdata[3:0];
        OFF_IRQ_MASK:  irq_mask_reg      <= wdata[3:0];
        OFF_LOAD:      interval_load_reg <= wdata;
        OFF_MATCH:     match_reg         <= wdata;
        OFF_PRESCALE:  prescale_reg      <= wdata[7:0];
        default:       ;
      endcase
    end
  end

  // Control: hardware clear of enable after one-shot or edge-count end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      control_reg <= 7'h00;
    end else if (wr && addr == OFF_CONTROL) begin
      control_reg <= wdata[6:0];
    end else if (hw_disable) begin
      control_reg[EN_BIT] <= 1'b0;
    end
  end

  // Sticky flags: set wins over write-one-to-clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      raw_irq_status_reg <= 4'h0;
    end else begin
      raw_irq_status_reg <= (raw_irq_status_reg &
        ~((wr && addr == OFF_IRQ_CLEAR) ? wdata[3:0] : 4'h0))
        | {set_rtc, set_ce, set_cm, set_to};
    end
  end

  // ******************************************************
  // Read port and outputs
  // ******************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= ZERO32;
    end else if (rd) begin
      case (addr)
        OFF_WIDTH_CFG:  rdata <= {29'h0, width_config_reg};
        OFF_MODE:       rdata <= {28'h0, timer_mode_reg};
        OFF_CONTROL:    rdata <= {25'h0, control_reg};
        OFF_IRQ_MASK:   rdata <= {28'h0, irq_mask_reg};
        OFF_RAW_STATUS: rdata <= {28'h0, raw_irq_status_reg};
        OFF_MSK_STATUS: rdata <= {28'h0, raw_irq_status_reg & irq_mask_reg};
        OFF_LOAD:       rdata <= interval_load_reg;
        OFF_MATCH:      rdata <= match_reg;
        OFF_PRESCALE:   rdata <= {24'h0, prescale_reg};
        OFF_VALUE:      rdata <= timer_value_reg;
        default:        rdata <= ZERO32;
      endcase
    end else begin
      rdata <= ZERO32;
    end
  end

  logic pwm_raw;

  // PWM raw level: set at load value, cleared at match
  always_ff @(posedge ref_clk) begin
    if (rst || !is_pwm || !en) begin
      pwm_raw <= 1'b0;
    end else if (next_count == interval_load_reg) begin
      pwm_raw <= 1'b1;
    end else if (next_count == match_reg) begin
      pwm_raw <= 1'b0;
    end
  end

  // Output flops: polarity, drive enable, masked interrupt
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwm_out     <= 1'b0;
      ccp_oe      <= 1'b0;
      irq_pending <= 1'b0;
    end else begin
      pwm_out     <= pwm_raw ^ control_reg[INV_BIT];
      ccp_oe      <= is_pwm;
      irq_pending <= |(raw_irq_status_reg & irq_mask_reg);
    end
  end

  // ******************************************************
  // Assertions
  // ******************************************************
  AST_ECOUNT_STOP: assert property (@(posedge ref_clk) disable iff (rst)
    (set_cm && !(wr && addr == OFF_CONTROL)) |=> !en)
    else $error("edge count did not disable");
  AST_CM_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
    set_cm |=> raw_irq_status_reg[CM_BIT])
    else $error("match flag not set");
  AST_CAPTURE_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    (is_etime && !set_ce && $past(is_etime)) |=> $stable(timer_value_reg))
    else $error("capture changed without edge");
  AST_CAPTURE_VAL: assert property (@(posedge ref_clk) disable iff (rst)
    set_ce |=> timer_value_reg == $past(count))
    else $error("capture value wrong");
  AST_PWM_NOFLAG: assert property (@(posedge ref_clk) disable iff (rst)
    is_pwm |-> !(set_to || set_cm || set_ce || set_rtc))
    else $error("flag raised in pwm mode");
  AST_STALL: assert property (@(posedge ref_clk) disable iff (rst)
    (stalled && !wr) |=> count == $past(count))
    else $error("counter moved while stalled");
  AST_RTC_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
    (set_rtc && !wr) |=> count == ZERO32)
    else $error("rtc did not wrap to zero");
  AST_PWM_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
    (!en ##1 !en ##1 !en) |-> pwm_out == $past(control_reg[INV_BIT]))
    else $error("idle pwm level wrong");
  AST_CLEAR: assert property (@(posedge ref_clk) disable iff (rst)
    (wr && addr == OFF_IRQ_CLEAR && wdata[TO_BIT] && !set_to)
      |=> !raw_irq_status_reg[TO_BIT])
    else $error("time-out flag not cleared");
  COV_ECOUNT: cover property (@(posedge ref_clk) set_cm);
  COV_ETIME: cover property (@(posedge ref_clk) set_ce);
  COV_PWM: cover property (@(posedge ref_clk) is_pwm && $rose(pwm_out));
  COV_RTC: cover property (@(posedge ref_clk) set_rtc);

endmodule : gtimer

// ---- tb/ccp_source.sv ----
// Pin model for the general timer: edge source or slow reference clock,
// and the load that sees the PWM drive while the timer owns the pin.
// Assumes ref_clk is the timer's system clock.
`timescale 1ns/10ps
module ccp_source (
  input  wire logic ref_clk,
  input  wire logic ccp_oe,
  input  wire logic pwm_out,
  output logic      pin
);
  logic src;

  initial src = 1'b0;

  // Timer drive wins while it owns the pin, else the source level
  assign pin = ccp_oe ? pwm_out : src;

  // Toggle n times, each level held gap cycles; gap of 4 or more
  task automatic toggle(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      src <= ~src;
      repeat (gap - 1) @(posedge ref_clk);
    end
  endtask : toggle

  // Slow reference clock: n rising edges, half period in cycles
  task automatic slow_clock(input int n, input int half);
    repeat (2 * n) toggle(1, half);
  endtask : slow_clock
endmodule : ccp_source

// ---- tb/test_gtimer.sv ----
// Testbench for the general timer: reset values, edge count, edge time,
// time-out modes, stall, PWM and RTC through the register port.
// Assumes gtimer_pkg, gtimer and ccp_source are compiled before it.
`timescale 1ns/10ps
module test_gtimer
  import gtimer_pkg::*;
;
  logic        ref_clk;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        ccp_pin;
  logic        pwm_out;
  logic        ccp_oe;
  logic        irq_pending;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  logic [31:0] rd_got;
  logic        rd_q;
  int          fails;
  int          checks_done;
  int          cycles;
  int          hi;
  logic [31:0] ld;
  logic [1:0]  md;
  logic [1:0]  evs [3] = '{EVT_RISE, EVT_FALL, EVT_BOTH};
  int          ncnt [3] = '{2, 2, 4};

  gtimer #(.RTC_DIVIDE(4)) gtimer_inst (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .capture_compare_pin(ccp_pin),
    .pwm_out(pwm_out), .ccp_oe(ccp_oe), .irq_pending(irq_pending));

  ccp_source ccp_source_inst (
    .ref_clk(ref_clk), .ccp_oe(ccp_oe), .pwm_out(pwm_out), .pin(ccp_pin));

  // ****************************************
  // Clock, bus tasks, read watcher
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      fails++;
      $display("MISMATCH %0t got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : reg_wr

  // Read with expected value under a mask; data compared by the watcher
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] x,
                        input logic [31:0] m);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back({m, x});
    @(posedge ref_clk);
    rd <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : reg_rd

  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    rd_q <= rd;
    if (rd_q === 1'b1) begin
      rd_got = rdata;
      e = exp_q.pop_front();
      checks_done++;
      if ((rdata & e[63:32]) !== (e[31:0] & e[63:32])) begin
        fails++;
        $display("MISMATCH %0t read got %h want %h", $time, rdata, e[31:0]);
      end
    end
  end

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq_pending !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    #1;
  endtask : wait_irq

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h00000000;
    wr = 1'b0;
    rd = 1'b0;
    rd_q = 1'b0;
    fails = 0;
    checks_done = 0;
    cycles = 0;
    void'($urandom(35231));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    reg_rd(OFF_LOAD, 32'h0000ffff, 32'hffffffff);
    reg_rd(OFF_VALUE, 32'h0000ffff, 32'hffffffff);
    reg_rd(OFF_CONTROL, 32'h00000000, 32'hffffffff);
    reg_rd(8'h08, 32'h00000000, 32'hffffffff);
    chk({31'h0, pwm_out}, 32'h0);
    $display("TB: reset test done");

    for (int i = 0; i < 3; i++) begin
      reg_wr(OFF_WIDTH_CFG, {29'h0, CFG_16BIT});
      reg_wr(OFF_MODE, 32'h00000003);
      reg_wr(OFF_CONTROL, {28'h0, evs[i], 2'b00});
      reg_wr(OFF_LOAD, 32'h0000000a);
      reg_wr(OFF_MATCH, 32'h0000000a - ncnt[i]);
      reg_wr(OFF_IRQ_MASK, 32'h00000002);
      reg_wr(OFF_CONTROL, {28'h0, evs[i], 2'b01});
      ccp_source_inst.toggle(4, 4 + $urandom_range(4));
      repeat (8) @(posedge ref_clk);
      chk({31'h0, irq_pending}, 32'h1);
      reg_rd(OFF_RAW_STATUS, 32'h2, 32'h2);
      reg_rd(OFF_CONTROL, 32'h0, 32'h1);
      ccp_source_inst.toggle(2, 5);
      repeat (8) @(posedge ref_clk);
      reg_rd(OFF_VALUE, 32'h0000000a, 32'h0000ffff);
      reg_wr(OFF_IRQ_CLEAR, 32'h00000002);
      reg_rd(OFF_RAW_STATUS, 32'h0, 32'h2);
      chk({31'h0, irq_pending}, 32'h0);
    end
    $display("TB: edge count test done");

    reg_wr(OFF_MODE, 32'h00000007);
    reg_wr(OFF_CONTROL, 32'h00000000);
    reg_wr(OFF_LOAD, 32'h00000030);
    reg_wr(OFF_IRQ_MASK, 32'h00000004);
    reg_wr(OFF_CONTROL, 32'h00000001);
    repeat (200) @(posedge ref_clk);
    ccp_source_inst.toggle(1, 8);
    repeat (4) @(posedge ref_clk);
    reg_rd(OFF_RAW_STATUS, 32'h4, 32'h4);
    reg_rd(OFF_VALUE, 32'h0, 32'h0);
    ld = rd_got;
    chk({31'h0, ld[15:0] <= 16'h0030}, 32'h1);
    ccp_source_inst.toggle(1, 8);
    repeat (20) @(posedge ref_clk);
    reg_rd(OFF_VALUE, ld, 32'h0000ffff);
    reg_wr(OFF_CONTROL, 32'h00000000);
    reg_wr(OFF_IRQ_CLEAR, 32'h00000004);
    $display("TB: edge time test done");

    for (int i = 0; i < 4; i++) begin
      md = i[0] ? MODE_PERIODIC : MODE_ONESHOT;
      ld = 32'h10 + $urandom_range(32'h30);
      reg_wr(OFF_WIDTH_CFG, i < 2 ? {29'h0, CFG_16BIT} : 32'h0);
      reg_wr(OFF_MODE, {30'h0, md});
      reg_wr(OFF_PRESCALE, 32'h00000000);
      reg_wr(OFF_LOAD, ld);
      reg_wr(OFF_IRQ_MASK, 32'h00000001);
      reg_wr(OFF_CONTROL, 32'h00000001);
      wait_irq(ld + 20);
      chk({31'h0, irq_pending}, 32'h1);
      reg_rd(OFF_CONTROL, {31'h0, md == MODE_PERIODIC}, 32'h1);
      reg_wr(OFF_CONTROL, 32'h00000000);
      reg_wr(OFF_IRQ_MASK, 32'h00000000);
      reg_rd(OFF_RAW_STATUS, 32'h1, 32'h1);
      chk({31'h0, irq_pending}, 32'h0);
      reg_wr(OFF_IRQ_CLEAR, 32'h00000001);
      reg_rd(OFF_RAW_STATUS, 32'h0, 32'h1);
    end
    reg_wr(OFF_WIDTH_CFG, {29'h0, CFG_16BIT});
    reg_wr(OFF_LOAD, 32'h0000ffff);
    reg_wr(OFF_CONTROL, 32'h00000003);
    repeat (30) @(posedge ref_clk);
    reg_rd(OFF_VALUE, 32'h0000ffff, 32'h0000ffff);
    reg_wr(OFF_CONTROL, 32'h00000000);
    $display("TB: time-out test done");

    reg_wr(OFF_MODE, 32'h0000000a);
    reg_wr(OFF_LOAD, 32'h00000013);
    reg_wr(OFF_MATCH, 32'h0000000a);
    for (int inv = 0; inv < 2; inv++) begin
      reg_wr(OFF_CONTROL, {25'h0, inv[0], 6'h01});
      repeat (50) @(posedge ref_clk);
      hi = 0;
      repeat (80) begin
        @(posedge ref_clk);
        #1;
        if (pwm_out === 1'b1) hi++;
      end
      chk(hi, inv ? 44 : 36);
      chk({31'h0, ccp_oe}, 32'h1);
      reg_wr(OFF_CONTROL, {25'h0, inv[0], 6'h00});
      repeat (4) @(posedge ref_clk);
      reg_rd(OFF_RAW_STATUS, 32'h0, 32'hffffffff);
      chk({31'h0, pwm_out}, inv);
    end
    $display("TB: pwm test done");

    reg_wr(OFF_MODE, 32'h00000000);
    reg_wr(OFF_WIDTH_CFG, {29'h0, CFG_RTC});
    reg_wr(OFF_MATCH, 32'h00000002);
    reg_wr(OFF_IRQ_MASK, 32'h00000008);
    reg_wr(OFF_CONTROL, 32'h00000011);
    ccp_source_inst.slow_clock(12, 4);
    repeat (6) @(posedge ref_clk);
    reg_rd(OFF_RAW_STATUS, 32'h8, 32'h8);
    reg_rd(OFF_CONTROL, 32'h1, 32'h1);
    reg_rd(OFF_VALUE, 32'h0, 32'h0);
    chk({31'h0, rd_got <= 32'h2}, 32'h1);
    chk({31'h0, irq_pending}, 32'h1);
    $display("TB: rtc test done");
    close_out();
  end
endmodule : test_gtimer
